// [src/dmc_pkg.sv]
// Constants shared by the display mode configuration block.
// Assumes one 250 MHz system clock and an 8-bit register port.
package dmc_pkg;
    // ****************************************************************
    // Register port and offsets
    // ****************************************************************
    localparam int       ADDR_W     = 8;
    localparam int       DATA_W     = 8;
    localparam logic [7:0] OFS_ID    = 8'h00;
    localparam logic [7:0] OFS_VIN   = 8'h01;
    localparam logic [7:0] OFS_DISP  = 8'h02;
    localparam logic [7:0] OFS_TOP   = 8'h03;
    localparam logic [7:0] OFS_BOT   = 8'h04;
    localparam logic [7:0] OFS_DUTY  = 8'h05;
    localparam logic [7:0] OFS_RAMP  = 8'h06;
    localparam logic [7:0] OFS_AGING = 8'h07;
    localparam logic [7:0] OFS_STATE = 8'h08;
    // ****************************************************************
    // Field positions
    // ****************************************************************
    localparam int VIN_FIELD_BIT   = 2;
    localparam int VIN_VPOL_BIT    = 1;
    localparam int VIN_HPOL_BIT    = 0;
    localparam int VIN_W           = 3;
    localparam int DISP_BLANK_BIT  = 5;
    localparam int DISP_STEREO_BIT = 4;
    localparam int DISP_STYLE_HI   = 3;
    localparam int DISP_STYLE_LO   = 2;
    localparam int DISP_VDIR_BIT   = 1;
    localparam int DISP_HDIR_BIT   = 0;
    localparam int DISP_W          = 6;
    localparam int POS_W           = 6;
    localparam int AGING_BIT       = 0;
    // ****************************************************************
    // Reset values
    // ****************************************************************
    localparam logic [2:0] VIN_RST  = 3'h0;
    localparam logic [5:0] DISP_RST = 6'h20;
    localparam logic [5:0] TOP_RST  = 6'h14;
    localparam logic [5:0] BOT_RST  = 6'h14;
    localparam logic [7:0] DUTY_RST = 8'h00;
    localparam logic [7:0] RAMP_RST = 8'h00;
    // ****************************************************************
    // Geometry and synchronised signal slots
    // ****************************************************************
    localparam int ROW_W = 9;
    localparam int COL_W = 10;
    localparam logic [8:0] ROW_LAST = 9'h1df;
    localparam logic [9:0] COL_LAST = 10'h27f;
    localparam int SIG_H = 0;
    localparam int SIG_V = 1;
    localparam int SIG_E = 2;
    localparam int SIG_N = 3;
    typedef enum logic [1:0] {STYLE_PROG, STYLE_INTER, STYLE_PSEUDO} dmc_style_type;
endpackage

// [src/dmc_sync_if.sv]
// Carrier for synchronised video timing inputs.
// Assumes producer and consumer share the system clock.
interface dmc_sync_if;
    import dmc_pkg::*;
    logic [SIG_N-1:0] lvl;
    logic [SIG_N-1:0] rise;
    logic [SIG_N-1:0] fall;
    modport src (output lvl, rise, fall);
    modport dst (input lvl, rise, fall);
endinterface

// [src/dmc_pin_sync.sv]
// Three-stage pin synchroniser with agreement filter and edge pulses.
// Assumes pins are asynchronous to the system clock.
module dmc_pin_sync
    import dmc_pkg::*;
(
    input  wire logic             clk,
    input  wire logic             rst_n,
    input  wire logic [SIG_N-1:0] pins,
    dmc_sync_if.src               sif
);
    logic [1:0] fill_reg;
    logic       primed;

    // Reset levels need not match the pins' idle levels; no edges until the stages are full
    assign primed = &fill_reg;

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            fill_reg <= 2'b00;
        else if (!primed)
            fill_reg <= fill_reg + 2'b01;
    end

    genvar i;
    generate
        for (i = 0; i < SIG_N; i++)
        begin : g_bit
            logic s1_reg;
            logic s2_reg;
            logic s3_reg;
            logic lvl_reg;
            logic lvl_next;
            // A change counts only once stages two and three agree
            assign lvl_next = (s2_reg == s3_reg) ? s3_reg : lvl_reg;
            always_ff @(posedge clk or negedge rst_n)
            begin
                if (!rst_n)
                begin
                    s1_reg  <= 1'b0;
                    s2_reg  <= 1'b0;
                    s3_reg  <= 1'b0;
                    lvl_reg <= 1'b0;
                    sif.rise[i] <= 1'b0;
                    sif.fall[i] <= 1'b0;
                end
                else
                begin
                    s1_reg  <= pins[i];
                    s2_reg  <= s1_reg;
                    s3_reg  <= s2_reg;
                    lvl_reg <= primed ? lvl_next : s2_reg;
                    sif.rise[i] <= primed & lvl_next & ~lvl_reg;
                    sif.fall[i] <= primed & ~lvl_next & lvl_reg;
                end
            end
            assign sif.lvl[i] = lvl_reg;
        end
    endgenerate
endmodule

// [src/dmc_scan_counter.sv]
// Loadable up/down scan counter.
// Assumes load is a one-cycle pulse; step may be held as a level and then counts once per system clock.
module dmc_scan_counter #(
    parameter int W = 9
) (
    input  wire logic         clk,
    input  wire logic         rst_n,
    input  wire logic         load,
    input  wire logic [W-1:0] start,
    input  wire logic         step,
    input  wire logic         down,
    input  wire logic [1:0]   inc,
    output logic      [W-1:0] value
);
    logic [W-1:0] value_reg;
    logic [W-1:0] value_next;
    logic [W-1:0] inc_w;

    assign inc_w = W'(inc);

    // Wraps silently; the row caller gates visibility by range, the column caller does not
    always_comb
    begin
        value_next = value_reg;
        if (load)
            value_next = start;
        else if (step)
            value_next = down ? W'(value_reg - inc_w) : W'(value_reg + inc_w);
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            value_reg <= '0;
        else
            value_reg <= value_next;
    end

    assign value = value_reg;
endmodule

// [src/dmc_mode_regs.sv]
// Display mode configuration registers and the scan logic they steer.
// Assumes a one-cycle strobe register port and asynchronous video pins.

module dmc_mode_regs
    import dmc_pkg::*;
#(
    // Arbitrary identification value
    parameter logic [7:0] REVISION = 8'h01
) (
    input  wire logic                      CLK_SYS,
    input  wire logic                      RESETN,
    input  wire logic [dmc_pkg::ADDR_W-1:0] ADDR,
    input  wire logic [dmc_pkg::DATA_W-1:0] WDATA,
    input  wire logic                      WR,
    input  wire logic                      RD,
    output logic      [dmc_pkg::DATA_W-1:0] RDATA,
    input  wire logic                      VSYNC_PIN,
    input  wire logic                      HSYNC_PIN,
    input  wire logic                      ENABLE_PIN,
    output logic                           DISPLAY_ON,
    output logic                           FIELD_EVEN,
    output logic                           EYE_RIGHT,
    output logic      [dmc_pkg::ROW_W-1:0]  ROW_ADDR,
    output logic      [dmc_pkg::COL_W-1:0]  COL_ADDR,
    output logic                           ROW_VISIBLE,
    output logic      [1:0]                SCAN_STYLE,
    output logic      [7:0]                ROW_DUTY,
    output logic      [7:0]                RAMP_CTRL
);
    import dmc_pkg::*;

    // ****************************************************************
    // Register storage
    // ****************************************************************
    logic [VIN_W-1:0]  vin_reg;
    logic [DISP_W-1:0] disp_reg;
    logic [POS_W-1:0]  top_reg;
    logic [POS_W-1:0]  bot_reg;
    logic [7:0]        duty_reg;
    logic [7:0]        ramp_reg;
    logic              aging_reg;
    logic [DATA_W-1:0] rdata_reg;
    logic [DATA_W-1:0] rdata_next;

    // ****************************************************************
    // Scan state
    // ****************************************************************
    logic              display_on_reg;
    logic              field_even_reg;
    logic              eye_right_reg;
    logic              row_visible_reg;
    logic              pseudo_phase_reg;
    logic [ROW_W-1:0]  row_value;
    logic [COL_W-1:0]  col_value;

    // ****************************************************************
    // Decoded settings
    // ****************************************************************
    logic              set_field;
    logic              vpol;
    logic              hpol;
    logic              blank;
    logic              stereo;
    dmc_style_type     style;
    logic              vdir;
    logic              hdir;
    logic              v_start;
    logic              h_start;
    logic              en_start;
    logic              odd_offset;
    logic [1:0]        row_inc;
    logic [ROW_W-1:0]  row_start;
    logic [COL_W-1:0]  col_start;
    logic [ROW_W-1:0]  row_first;
    logic [ROW_W-1:0]  row_last;

    dmc_sync_if sync_bus ();

    // ****************************************************************
    // Pin synchronisation
    // ****************************************************************
    dmc_pin_sync u_sync (
        .clk   (CLK_SYS),
        .rst_n (RESETN),
        .pins  ({ENABLE_PIN, VSYNC_PIN, HSYNC_PIN}),
        .sif   (sync_bus.src)
    );

    // ****************************************************************
    // Register writes
    // ****************************************************************
    always_ff @(posedge CLK_SYS or negedge RESETN)
    begin
        if (!RESETN)
            vin_reg <= VIN_RST;
        else if (WR && ADDR == OFS_VIN)
            vin_reg <= WDATA[VIN_W-1:0];
    end

    always_ff @(posedge CLK_SYS or negedge RESETN)
    begin
        if (!RESETN)
            disp_reg <= DISP_RST;
        else if (WR && ADDR == OFS_DISP)
            disp_reg <= WDATA[DISP_W-1:0];
    end

    always_ff @(posedge CLK_SYS or negedge RESETN)
    begin
        if (!RESETN)
        begin
            top_reg <= TOP_RST;
            bot_reg <= BOT_RST;
        end
        else if (WR && ADDR == OFS_TOP)
            top_reg <= WDATA[POS_W-1:0];
        else if (WR && ADDR == OFS_BOT)
            bot_reg <= WDATA[POS_W-1:0];
    end

    always_ff @(posedge CLK_SYS or negedge RESETN)
    begin
        if (!RESETN)
        begin
            duty_reg  <= DUTY_RST;
            ramp_reg  <= RAMP_RST;
            aging_reg <= 1'b0;
        end
        else if (WR)
        begin
            if (ADDR == OFS_DUTY)
                duty_reg <= WDATA;
            if (ADDR == OFS_RAMP)
                ramp_reg <= WDATA;
            if (ADDR == OFS_AGING)
                aging_reg <= WDATA[AGING_BIT];
        end
    end

    // ****************************************************************
    // Register reads
    // ****************************************************************
    // Unused bits and unmapped offsets read as zero
    always_comb
    begin
        rdata_next = '0;
        unique case (ADDR)
            OFS_ID:    rdata_next = REVISION;
            OFS_VIN:   rdata_next[VIN_W-1:0] = vin_reg;
            OFS_DISP:  rdata_next[DISP_W-1:0] = disp_reg;
            OFS_TOP:   rdata_next[POS_W-1:0] = top_reg;
            OFS_BOT:   rdata_next[POS_W-1:0] = bot_reg;
            OFS_DUTY:  rdata_next = duty_reg;
            OFS_RAMP:  rdata_next = ramp_reg;
            OFS_AGING: rdata_next[AGING_BIT] = aging_reg;
            OFS_STATE: rdata_next[3:0] = {row_visible_reg, eye_right_reg,
                                          field_even_reg, display_on_reg};
            default:   rdata_next = '0;
        endcase
    end

    // Read data stands for exactly the cycle after the strobe
    always_ff @(posedge CLK_SYS or negedge RESETN)
    begin
        if (!RESETN)
            rdata_reg <= '0;
        else if (RD)
            rdata_reg <= rdata_next;
        else
            rdata_reg <= '0;
    end

    // ****************************************************************
    // Setting decode
    // ****************************************************************
    assign set_field = vin_reg[VIN_FIELD_BIT];
    assign vpol      = vin_reg[VIN_VPOL_BIT];
    assign hpol      = vin_reg[VIN_HPOL_BIT];
    assign blank     = disp_reg[DISP_BLANK_BIT];
    assign stereo    = disp_reg[DISP_STEREO_BIT];
    assign vdir      = disp_reg[DISP_VDIR_BIT];
    assign hdir      = disp_reg[DISP_HDIR_BIT];

    always_comb
    begin
        // Upper bit set means pseudo-interlaced regardless of low bit
        if (disp_reg[DISP_STYLE_HI])
            style = STYLE_PSEUDO;
        else if (disp_reg[DISP_STYLE_LO])
            style = STYLE_INTER;
        else
            style = STYLE_PROG;
    end

    // Active sync edge follows the programmed polarity
    assign v_start  = vpol ? sync_bus.rise[SIG_V] : sync_bus.fall[SIG_V];
    assign h_start  = hpol ? sync_bus.rise[SIG_H] : sync_bus.fall[SIG_H];
    assign en_start = sync_bus.rise[SIG_E];

    // ****************************************************************
    // Field and stereo tracking
    // ****************************************************************
    always_ff @(posedge CLK_SYS or negedge RESETN)
    begin
        if (!RESETN)
            field_even_reg <= 1'b0;
        else if (en_start)
            field_even_reg <= set_field;
    end

    always_ff @(posedge CLK_SYS or negedge RESETN)
    begin
        if (!RESETN)
            eye_right_reg <= 1'b0;
        else if (!stereo)
            eye_right_reg <= 1'b0;
        else if (v_start)
            eye_right_reg <= ~eye_right_reg;
    end

    // Pseudo-interlace makes its own field phase, ignoring the input field
    always_ff @(posedge CLK_SYS or negedge RESETN)
    begin
        if (!RESETN)
            pseudo_phase_reg <= 1'b0;
        else if (style != STYLE_PSEUDO)
            pseudo_phase_reg <= 1'b0;
        else if (v_start)
            pseudo_phase_reg <= ~pseudo_phase_reg;
    end

    // ****************************************************************
    // Display enable
    // ****************************************************************
    always_ff @(posedge CLK_SYS or negedge RESETN)
    begin
        if (!RESETN)
            display_on_reg <= 1'b0;
        else
            display_on_reg <= ~blank | aging_reg;
    end

    // ****************************************************************
    // Row scan
    // ****************************************************************
    always_comb
    begin
        odd_offset = 1'b0;
        row_inc    = 2'd1;
        unique case (style)
            STYLE_PROG:
            begin
                odd_offset = 1'b0;
                row_inc    = 2'd1;
            end
            STYLE_INTER:
            begin
                odd_offset = field_even_reg;
                row_inc    = 2'd2;
            end
            STYLE_PSEUDO:
            begin
                odd_offset = pseudo_phase_reg;
                row_inc    = 2'd2;
            end
        endcase
    end

    // Bottom-up scan starts at the last row less the field offset and counts down
    assign row_start = vdir ? ROW_LAST - ROW_W'(odd_offset)
                            : ROW_W'(odd_offset);

    dmc_scan_counter #(
        .W (ROW_W)
    ) u_row (
        .clk   (CLK_SYS),
        .rst_n (RESETN),
        .load  (v_start),
        .start (row_start),
        .step  (h_start),
        .down  (vdir),
        .inc   (row_inc),
        .value (row_value)
    );

    // ****************************************************************
    // Column scan
    // ****************************************************************
    assign col_start = hdir ? COL_LAST : '0;

    dmc_scan_counter #(
        .W (COL_W)
    ) u_col (
        .clk   (CLK_SYS),
        .rst_n (RESETN),
        .load  (h_start),
        .start (col_start),
        .step  (sync_bus.lvl[SIG_E]),
        .down  (hdir),
        .inc   (2'd1),
        .value (col_value)
    );

    // ****************************************************************
    // Visible row window
    // ****************************************************************
    // Bottom position is a margin above the last physical row
    assign row_first = ROW_W'(top_reg);
    assign row_last  = ROW_LAST - ROW_W'(bot_reg);

    always_ff @(posedge CLK_SYS or negedge RESETN)
    begin
        if (!RESETN)
            row_visible_reg <= 1'b0;
        else
            row_visible_reg <= (row_value >= row_first) && (row_value <= row_last);
    end

    // ****************************************************************
    // Outputs
    // ****************************************************************
    assign RDATA       = rdata_reg;
    assign DISPLAY_ON  = display_on_reg;
    assign FIELD_EVEN  = field_even_reg;
    assign EYE_RIGHT   = eye_right_reg;
    assign ROW_ADDR    = row_value;
    assign COL_ADDR    = col_value;
    assign ROW_VISIBLE = row_visible_reg;
    assign SCAN_STYLE  = disp_reg[DISP_STYLE_HI:DISP_STYLE_LO];
    assign ROW_DUTY    = duty_reg;
    assign RAMP_CTRL   = ramp_reg;
endmodule

// [verification/dmc_mode_regs_asserts.sv]
// Concurrent checks on the register port and mode outputs of dmc_mode_regs.
// Assumes the single system clock domain and the port timing of the hand-over.
module dmc_mode_regs_asserts
    import dmc_pkg::*;
(
    input wire logic                         CLK_SYS,
    input wire logic                         RESETN,
    input wire logic [dmc_pkg::ADDR_W-1:0]   ADDR,
    input wire logic [dmc_pkg::DATA_W-1:0]   WDATA,
    input wire logic                         WR,
    input wire logic                         RD,
    input wire logic [dmc_pkg::DATA_W-1:0]   RDATA,
    input wire logic                         DISPLAY_ON,
    input wire logic                         EYE_RIGHT,
    input wire logic [1:0]                   SCAN_STYLE
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (!RESETN);
    // ************************************************************
    // Sequences
    // ************************************************************
    sequence s_disp_write;
        WR && ADDR == OFS_DISP;
    endsequence
    sequence s_read(logic [7:0] a);
        RD && ADDR == a;
    endsequence
    // ************************************************************
    // Properties
    // ************************************************************
    // Derived outputs lag the register by one more edge
    property p_show_on;
        s_disp_write ##0 !WDATA[DISP_BLANK_BIT] |-> ##2 DISPLAY_ON;
    endproperty
    property p_aging_on;
        WR && ADDR == OFS_AGING && WDATA[AGING_BIT] |-> ##2 DISPLAY_ON;
    endproperty
    property p_stereo_off;
        s_disp_write ##0 !WDATA[DISP_STEREO_BIT] |-> ##2 !EYE_RIGHT;
    endproperty
    property p_style_follow;
        s_disp_write |=> SCAN_STYLE == $past(WDATA[3:2]);
    endproperty
    property p_style_hold;
        !(WR && ADDR == OFS_DISP) |=> $stable(SCAN_STYLE);
    endproperty
    property p_bot_width;
        s_read(OFS_BOT) |=> RDATA[7:6] == 2'b00;
    endproperty
    property p_vin_width;
        s_read(OFS_VIN) |=> RDATA[7:3] == 5'h00;
    endproperty
    property p_rdata_idle;
        !RD |=> RDATA == 8'h00;
    endproperty
    property p_unmapped;
        RD && ADDR > OFS_STATE |=> RDATA == 8'h00;
    endproperty
    a_show_on: assert property (p_show_on) else $error("display off after blank cleared");
    a_aging_on: assert property (p_aging_on) else $error("aging did not force display");
    a_stereo_off: assert property (p_stereo_off) else $error("eye select not cleared");
    a_style_follow: assert property (p_style_follow) else $error("scan style not written");
    a_style_hold: assert property (p_style_hold) else $error("scan style changed alone");
    a_bot_width: assert property (p_bot_width) else $error("bottom position over six bits");
    a_vin_width: assert property (p_vin_width) else $error("input mode unused bits set");
    a_rdata_idle: assert property (p_rdata_idle) else $error("read data not zero when idle");
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
endmodule

bind dmc_mode_regs dmc_mode_regs_asserts u_dmc_mode_regs_asserts (
    .CLK_SYS    (CLK_SYS),
    .RESETN     (RESETN),
    .ADDR       (ADDR),
    .WDATA      (WDATA),
    .WR         (WR),
    .RD         (RD),
    .RDATA      (RDATA),
    .DISPLAY_ON (DISPLAY_ON),
    .EYE_RIGHT  (EYE_RIGHT),
    .SCAN_STYLE (SCAN_STYLE)
);

// [verification/tb_dmc_mode_regs.sv]
// Self-checking bench for dmc_mode_regs: register port and video pin scenarios.
// Assumes the checker is bound separately and the design package is compiled first.
module tb_dmc_mode_regs;
    timeunit 1ns;
    timeprecision 100ps;
    import dmc_pkg::*;
    // Arbitrary revision value, handed to the design
    localparam logic [7:0] REV_EXP = 8'h01;
    logic       clk_sys;
    logic       resetn;
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
    logic [7:0] rdata;
    logic [2:0] pins;
    logic       display_on;
    logic       field_even;
    logic       eye_right;
    logic [8:0] row_addr;
    logic [9:0] col_addr;
    logic [1:0] scan_style;
    logic [7:0] row_duty;
    logic       row_visible;
    logic [7:0] ramp_ctrl;
    int         mismatches;
    int         compares;
    dmc_mode_regs #(.REVISION(REV_EXP)) u_dmc_mode_regs (
        .CLK_SYS     (clk_sys),
        .RESETN      (resetn),
        .ADDR        (addr),
        .WDATA       (wdata),
        .WR          (wr),
        .RD          (rd),
        .RDATA       (rdata),
        .VSYNC_PIN   (pins[SIG_V]),
        .HSYNC_PIN   (pins[SIG_H]),
        .ENABLE_PIN  (pins[SIG_E]),
        .DISPLAY_ON  (display_on),
        .FIELD_EVEN  (field_even),
        .EYE_RIGHT   (eye_right),
        .ROW_ADDR    (row_addr),
        .COL_ADDR    (col_addr),
        .ROW_VISIBLE (row_visible),
        .SCAN_STYLE  (scan_style),
        .ROW_DUTY    (row_duty),
        .RAMP_CTRL   (ramp_ctrl)
    );
    // ************************************************************
    // Tasks
    // ************************************************************
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge clk_sys);
        wr    <= 1'b0;
        // Step off the edge so callers see the written value
        #1;
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk_sys);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clk_sys);
        rd   <= 1'b0;
        @(negedge clk_sys);
        check("register read", 16'(rdata), 16'(exp));
    endtask
    // Synchroniser and edge pulse need about four edges; ten leaves margin
    task automatic pin(input int idx, input logic v);
        @(posedge clk_sys);
        pins[idx] <= v;
        repeat (10) @(posedge clk_sys);
        #1;
    endtask
    task automatic settle;
        @(posedge clk_sys);
        #1;
    endtask
    task automatic wrap_up;
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    // ************************************************************
    // Clock, watchdog and main sequence
    // ************************************************************
    initial
    begin
        clk_sys = 1'b0;
        forever #2 clk_sys = ~clk_sys;
    end
    initial
    begin
        #100000;
        mismatches++;
        wrap_up();
    end
    initial
    begin
        resetn = 1'b0;
        addr = 8'h00;
        wdata = 8'h00;
        wr = 1'b0;
        rd = 1'b0;
        pins = 3'b011;
        mismatches = 0;
        compares = 0;
        repeat (3) @(posedge clk_sys);
        resetn <= 1'b1;
        settle();
        check("display on", 16'(display_on), 16'h0000);
        rd_chk(OFS_VIN, 8'h00);
        rd_chk(OFS_DISP, 8'h20);
        rd_chk(OFS_TOP, 8'h14);
        rd_chk(OFS_BOT, 8'h14);
        rd_chk(OFS_DUTY, 8'h00);
        rd_chk(OFS_RAMP, 8'h00);
        wr_reg(OFS_ID, 8'hff);
        rd_chk(OFS_ID, REV_EXP);
        rd_chk(8'h5a, 8'h00);
        wr_reg(OFS_BOT, 8'hff);
        rd_chk(OFS_BOT, 8'h3f);
        wr_reg(OFS_DUTY, 8'ha5);
        check("row duty", 16'(row_duty), 16'h00a5);
        wr_reg(OFS_RAMP, 8'h5c);
        check("ramp control", 16'(ramp_ctrl), 16'h005c);
        rd_chk(OFS_RAMP, 8'h5c);
        wr_reg(OFS_VIN, 8'hff);
        rd_chk(OFS_VIN, 8'h07);
        for (int i = 0; i < 4; i++)
        begin
            wr_reg(OFS_DISP, 8'h20 | 8'(i << 2));
            settle();
            check("scan style", 16'(scan_style), 16'(i));
        end
        wr_reg(OFS_DISP, 8'h00);
        settle();
        check("display on", 16'(display_on), 16'h0001);
        wr_reg(OFS_DISP, 8'h20);
        settle();
        check("display on", 16'(display_on), 16'h0000);
        wr_reg(OFS_AGING, 8'h01);
        rd_chk(OFS_AGING, 8'h01);
        settle();
        check("display on", 16'(display_on), 16'h0001);
        wr_reg(OFS_AGING, 8'h00);
        settle();
        check("display on", 16'(display_on), 16'h0000);
        // Positive vertical sync, bottom to top, stereo on
        wr_reg(OFS_DISP, 8'h32);
        pin(SIG_V, 1'b0);
        check("row address", 16'(row_addr), 16'h0000);
        pin(SIG_V, 1'b1);
        check("row address", 16'(row_addr), 16'(ROW_LAST));
        check("eye select", 16'(eye_right), 16'h0001);
        // Negative polarities, top to bottom, stereo off, field bit set
        wr_reg(OFS_VIN, 8'h04);
        wr_reg(OFS_DISP, 8'h20);
        settle();
        check("eye select", 16'(eye_right), 16'h0000);
        pin(SIG_V, 1'b0);
        check("row address", 16'(row_addr), 16'h0000);
        wr_reg(OFS_DISP, 8'h21);
        pin(SIG_H, 1'b0);
        check("column address", 16'(col_addr), 16'(COL_LAST));
        pin(SIG_H, 1'b1);
        check("column address", 16'(col_addr), 16'(COL_LAST));
        pin(SIG_E, 1'b1);
        check("field even", 16'(field_even), 16'h0001);
        pin(SIG_E, 1'b0);
        wr_reg(OFS_VIN, 8'h00);
        pin(SIG_E, 1'b1);
        check("field even", 16'(field_even), 16'h0000);
        pin(SIG_E, 1'b0);
        wr_reg(OFS_DISP, 8'h20);
        pin(SIG_H, 1'b0);
        check("column address", 16'(col_addr), 16'h0000);
        // Interlaced, odd field, top to bottom: rows advance by two
        wr_reg(OFS_DISP, 8'h24);
        pin(SIG_V, 1'b1);
        pin(SIG_V, 1'b0);
        check("row address", 16'(row_addr), 16'h0000);
        pin(SIG_H, 1'b1);
        pin(SIG_H, 1'b0);
        check("row address", 16'(row_addr), 16'h0002);
        // Bottom-up start sits on the last row; zero margin keeps it visible
        wr_reg(OFS_DISP, 8'h22);
        pin(SIG_V, 1'b1);
        pin(SIG_V, 1'b0);
        wr_reg(OFS_BOT, 8'h00);
        settle();
        check("row visible", 16'(row_visible), 16'h0001);
        rd_chk(OFS_STATE, 8'h08);
        wr_reg(OFS_BOT, 8'h01);
        settle();
        check("row visible", 16'(row_visible), 16'h0000);
        wrap_up();
    end
endmodule
